// File: hdl/tmo_timer.sv
// sixteen-bit timer/counter with prescaler, sync stage and overflow flag
`timescale 1ns/1ps
// Contract
// R1 - 16-bit count, two bytes, wraps to zero
// R2 - wrap latches overflow flag at bit 0
// R3 - interrupt request gated by enable bit 0
// R4 - control bit 1 selects count source
// R5 - timer mode counts every instruction cycle
// R6 - control bit 0 runs or holds count
// R7 - bits 5-4 prescale 1, 2, 4, 8
// R8 - control bit 3 enables low-power oscillator
// R9 - oscillator on: pins inputs, read zero
// R10 - bit 2 sync select, external source only
// R11 - falling edge needed before first count
// R12 - oscillator on selects oscillator input pin
// R13 - prescaler before sync stage
// R14 - sync counter halts in sleep, prescaler runs
// R15 - async counter runs in sleep, wakes
// R16 - no time base in async mode
// R17 - each byte read coherent
// R18 - software corrects overflow between byte reads
// R19 - software stops counter before writing
// R20 - capture/compare units may reset count
// R21 - oscillator keeps running in sleep
// R22 - software waits for oscillator start-up
// R23 - count write beats capture/compare reset
// R24 - capture/compare reset sets no flag
// R25 - count byte write clears prescaler
// R26 - control cleared by reset, count kept
module tmo_timer
    import tmo_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WE,
    input  wire logic        RE,
    output logic      [7:0]  RDATA,
    input  wire logic        SLEEP,
    input  wire logic        CAPCMP1_TRIG,
    input  wire logic        CAPCMP2_TRIG,
    input  wire logic [1:0]  PORT_DIR,
    input  wire logic [1:0]  PORT_OUT,
    input  wire logic [1:0]  PIN_I,
    output logic      [1:0]  PIN_O,
    output logic      [1:0]  PIN_OE,
    output logic      [1:0]  PIN_RD,
    output logic             OSC_RUN,
    output logic             IRQ,
    output logic             WAKE,
    output logic      [15:0] TIME_BASE,
    output logic             TIME_BASE_VALID
);

    // ==========================================================
    // functions
    function automatic logic prescale_done(input logic [2:0] cnt,
                                           input logic [1:0] sel);
        logic [2:0] mask;
        mask = 3'(({3'h0, 1'b1} << sel) - 4'h1);
        prescale_done = ((cnt & mask) == mask);
    endfunction

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ==========================================================
    // registers
    logic [7:0]  ctrl_r;
    logic        flag_r;
    logic        ena_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [2:0]  pre_r;
    logic [1:0]  phase_r;
    logic [1:0]  pin_q_r;
    logic        pin_prev;
    logic        armed_r;
    logic        run_q_r;
    logic        sync1_r;
    logic        sync2_r;
    logic        sync3_r;
    tmo_ctrl_s   ctrl;
    tmo_mode_e   mode;
    logic        instr_en;
    logic        cnt_pin;
    logic        rise;
    logic        fall;
    logic        pre_in;
    logic        pre_out;
    logic        inc;
    logic        wr_lo;
    logic        wr_hi;
    logic        capcmp_clr;
    logic        wrap;

    assign ctrl = tmo_ctrl_s'(ctrl_r[5:0]);

    always_comb begin
        if (!ctrl.count_source_select) begin
            mode = TMO_MODE_TIMER; // see R4
        end else if (ctrl.sync_bypass) begin
            mode = TMO_MODE_ASYNC; // see R10
        end else begin
            mode = TMO_MODE_SYNC;
        end
    end

    assign wr_lo = WE && hit(ADDR, TMO_OFS_CNT_LO);
    assign wr_hi = WE && hit(ADDR, TMO_OFS_CNT_HI);

    // ==========================================================
    // instruction cycle divider, oscillator stops in sleep
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            phase_r <= 2'h0;
        end else if (!SLEEP) begin
            phase_r <= phase_r + 2'h1;
        end
    end

    assign instr_en = !SLEEP && (phase_r == TMO_PHASE_LAST);

    // ==========================================================
    // pins and edge detection
    // history kept per pin, so moving the selection makes no false edge
    assign cnt_pin  = ctrl.osc_enable ? PIN_I[1] : PIN_I[0]; // see R12
    assign pin_prev = ctrl.osc_enable ? pin_q_r[1] : pin_q_r[0];
    assign rise     = cnt_pin && !pin_prev;
    assign fall     = !cnt_pin && pin_prev;

    // low-power oscillator stays up in sleep
    assign OSC_RUN = ctrl.osc_enable; // see R8, R21

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            PIN_OE[i] = !PORT_DIR[i] && !ctrl.osc_enable; // see R9
            PIN_O[i]  = PORT_OUT[i] && !ctrl.osc_enable;
            PIN_RD[i] = PIN_I[i] && !ctrl.osc_enable;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pin_q_r <= 2'h0;
            run_q_r <= 1'b0;
        end else begin
            pin_q_r <= PIN_I;
            run_q_r <= ctrl.run_enable && ctrl.count_source_select;
        end
    end

    // counting waits for a falling edge after enable in counter mode
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            armed_r <= 1'b0;
        end else if (!(ctrl.run_enable && ctrl.count_source_select)) begin
            armed_r <= 1'b0;
        end else if (!run_q_r) begin
            armed_r <= fall; // see R11
        end else if (fall) begin
            armed_r <= 1'b1; // see R11
        end
    end

    // ==========================================================
    // prescaler on raw input ahead of the sync stage
    always_comb begin
        if (mode == TMO_MODE_TIMER) begin
            pre_in = ctrl.run_enable && instr_en; // see R5
        end else begin
            pre_in = ctrl.run_enable && armed_r && rise;
        end
    end

    assign pre_out = pre_in && prescale_done(pre_r, ctrl.prescale_select); // see R7

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pre_r <= 3'h0;
        end else if (wr_lo || wr_hi) begin
            pre_r <= 3'h0; // see R25
        end else if (pre_in) begin
            pre_r <= pre_out ? 3'h0 : pre_r + 3'h1; // see R13, R14
        end
    end

    // ==========================================================
    // sync stage after prescaler; halted in sleep, edges lost then
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else if (SLEEP || mode != TMO_MODE_SYNC) begin
            sync1_r <= 1'b0; // see R14
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= pre_out; // see R13
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_comb begin
        case (mode)
            TMO_MODE_TIMER: inc = pre_out; // see R5
            TMO_MODE_SYNC:  inc = sync2_r && !sync3_r && ctrl.run_enable;
            TMO_MODE_ASYNC: inc = pre_out; // see R15
            default:        inc = 1'b0;
        endcase
    end

    // ==========================================================
    // count register; not touched by reset, so no reset branch
    // async mode may miss the trigger, so it is ignored there
    assign capcmp_clr = (CAPCMP1_TRIG || CAPCMP2_TRIG) && mode != TMO_MODE_ASYNC; // see R20
    assign wrap       = inc && !(wr_lo || wr_hi) && !capcmp_clr
                        && (count_r == TMO_CNT_MAX);

    always_comb begin
        count_nxt = count_r;
        if (wr_lo || wr_hi) begin
            if (wr_lo) begin
                count_nxt[7:0] = WDATA; // see R1, R23
            end
            if (wr_hi) begin
                count_nxt[15:8] = WDATA;
            end
        end else if (capcmp_clr) begin
            count_nxt = TMO_CNT_ZERO; // see R24
        end else if (inc) begin
            count_nxt = count_r + 16'h0001; // see R1, R6
        end
    end

    always_ff @(posedge CLK) begin
        count_r <= count_nxt; // see R26
    end

    assign TIME_BASE       = count_r;
    assign TIME_BASE_VALID = (mode != TMO_MODE_ASYNC); // see R16

    // ==========================================================
    // control and interrupt registers
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ctrl_r <= TMO_CTRL_RESET; // see R26
        end else if (WE && hit(ADDR, TMO_OFS_CTRL)) begin
            ctrl_r <= WDATA & TMO_CTRL_MASK;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            flag_r <= TMO_FLAG_RESET[TMO_BIT_OVF];
        end else if (wrap) begin
            flag_r <= 1'b1; // see R2
        end else if (WE && hit(ADDR, TMO_OFS_FLAG)) begin
            flag_r <= WDATA[TMO_BIT_OVF];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ena_r <= TMO_ENA_RESET[TMO_BIT_OVF];
        end else if (WE && hit(ADDR, TMO_OFS_ENABLE)) begin
            ena_r <= WDATA[TMO_BIT_OVF];
        end
    end

    assign IRQ  = flag_r && ena_r; // see R3
    assign WAKE = IRQ && SLEEP; // see R15

    // ==========================================================
    // read port; single clock, so each byte is sampled whole
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (RE) begin
            case (ADDR)
                TMO_OFS_CNT_LO: RDATA <= count_r[7:0]; // see R17
                TMO_OFS_CNT_HI: RDATA <= count_r[15:8]; // see R17
                TMO_OFS_CTRL:   RDATA <= ctrl_r;
                TMO_OFS_FLAG:   RDATA <= {7'h00, flag_r};
                TMO_OFS_ENABLE: RDATA <= {7'h00, ena_r};
                default:        RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

endmodule

// File: include/tmo_pkg.sv
// constants and types for the sixteen-bit timer/counter
package tmo_pkg;

    // ==========================================================
    // register map (byte offsets on the 8-bit register port)
    localparam logic [7:0] TMO_OFS_FLAG    = 8'h0C;
    localparam logic [7:0] TMO_OFS_CNT_LO  = 8'h0E;
    localparam logic [7:0] TMO_OFS_CNT_HI  = 8'h0F;
    localparam logic [7:0] TMO_OFS_CTRL    = 8'h10;
    localparam logic [7:0] TMO_OFS_ENABLE  = 8'h8C;

    // ==========================================================
    // control, flag and enable register fields and reset values
    localparam int         TMO_BIT_RUN     = 0;
    localparam int         TMO_BIT_SRC     = 1;
    localparam int         TMO_BIT_NOSYNC  = 2;
    localparam int         TMO_BIT_OSCEN   = 3;
    localparam int         TMO_BIT_PS_LO   = 4;
    localparam int         TMO_BIT_OVF     = 0;
    localparam logic [7:0] TMO_CTRL_MASK   = 8'h3F;
    localparam logic [7:0] TMO_CTRL_RESET  = 8'h00;
    localparam logic [7:0] TMO_FLAG_RESET  = 8'h00;
    localparam logic [7:0] TMO_ENA_RESET   = 8'h00;

    // ==========================================================
    // timing: instruction cycle is one quarter of the oscillator
    localparam int         TMO_OSC_PER_INSTR = 4;
    localparam logic [1:0] TMO_PHASE_LAST    = 2'(TMO_OSC_PER_INSTR - 1);
    localparam logic [15:0] TMO_CNT_MAX      = 16'hFFFF;
    localparam logic [15:0] TMO_CNT_ZERO     = 16'h0000;

    // ==========================================================
    // decoded control fields
    typedef struct packed {
        logic [1:0] prescale_select;
        logic       osc_enable;
        logic       sync_bypass;
        logic       count_source_select;
        logic       run_enable;
    } tmo_ctrl_s;

    typedef enum logic [1:0] {
        TMO_MODE_TIMER,
        TMO_MODE_SYNC,
        TMO_MODE_ASYNC
    } tmo_mode_e;

endpackage

// File: sim/tmo_timer_assertions.sv
// port assertions for the timer/counter
`timescale 1ns/1ps
module tmo_timer_chk
    import tmo_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic [7:0]  ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WE,
    input wire logic        RE,
    input wire logic [7:0]  RDATA,
    input wire logic        SLEEP,
    input wire logic        CAPCMP1_TRIG,
    input wire logic        CAPCMP2_TRIG,
    input wire logic [1:0]  PORT_DIR,
    input wire logic [1:0]  PORT_OUT,
    input wire logic [1:0]  PIN_O,
    input wire logic [1:0]  PIN_OE,
    input wire logic [1:0]  PIN_RD,
    input wire logic        OSC_RUN,
    input wire logic        IRQ,
    input wire logic        WAKE,
    input wire logic [15:0] TIME_BASE,
    input wire logic        TIME_BASE_VALID
);
    logic cnt_wr;
    assign cnt_wr = WE && (ADDR == TMO_OFS_CNT_LO || ADDR == TMO_OFS_CNT_HI);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // ========================================
    // steps
    sequence s_ctrl_wr;
        WE && ADDR == TMO_OFS_CTRL;
    endsequence
    // count write has priority, so it masks the clear
    sequence s_trig;
        (CAPCMP1_TRIG || CAPCMP2_TRIG) && !cnt_wr && TIME_BASE_VALID;
    endsequence
    // ========================================
    // checks
    a_osc_follow: assert property (s_ctrl_wr |=> OSC_RUN == $past(WDATA[TMO_BIT_OSCEN]))
        else $error("oscillator run not following control write");
    a_reset_clears: assert property (disable iff (1'b0) !RSTN |=> !OSC_RUN && !IRQ)
        else $error("control not cleared by reset");
    a_count_step: assert property (!$past(WE) && !$past(CAPCMP1_TRIG)
        && !$past(CAPCMP2_TRIG) && $changed(TIME_BASE)
        |-> TIME_BASE == 16'($past(TIME_BASE) + 16'h0001))
        else $error("count moved by other than one");
    a_trig_clear: assert property (s_trig |=> TIME_BASE == TMO_CNT_ZERO)
        else $error("trigger did not clear count");
    a_rd_idle: assert property (!$past(RE) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
    a_pin_dir: assert property (PIN_OE == (~PORT_DIR & {2{!OSC_RUN}}))
        else $error("pin drive wrong");
    a_pin_read: assert property (OSC_RUN |-> PIN_RD == 2'b00)
        else $error("pins not reading zero");
    a_pin_out: assert property (PIN_O == (PORT_OUT & {2{!OSC_RUN}}))
        else $error("pin output not gated by oscillator");
    a_wake_level: assert property (WAKE == (IRQ && SLEEP))
        else $error("wake not following request in sleep");
endmodule

// File: sim/tmo_pin_src.sv
// external clock source for the count pins
`timescale 1ns/1ps
module tmo_pin_src (
    input  wire logic       clk,
    output logic      [1:0] pin_i
);
    initial pin_i = 2'b00;
    // clock stands still between bursts
    task automatic set(input int sel, input logic v);
        @(posedge clk);
        pin_i[sel] <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic pulses(input int sel, input int n, input int w);
        repeat (n) begin
            repeat (w) @(posedge clk);
            pin_i[sel] <= 1'b0;
            repeat (w) @(posedge clk);
            pin_i[sel] <= 1'b1;
        end
        repeat (6) @(posedge clk);
    endtask
endmodule

// File: sim/test_tmo_timer.sv
// self-checking bench for the timer/counter
`timescale 1ns/1ps
module test_tmo_timer;
    import tmo_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, sleep = 1'b0, osc_run, irq, wake;
    logic        tbv;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, got;
    logic [1:0]  dir = 2'b11, pout = 2'b00, trg = 2'b00, pin;
    logic [7:0]  md [3] = '{8'h03, 8'h07, 8'h0B};
    logic [31:0] seed = 32'hC215;
    int          err_count = 0, num_checks = 0, cyc = 0, ec, n;
    always #2.5 clk = ~clk;
    tmo_pin_src src (.clk(clk), .pin_i(pin));
    tmo_timer dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re),
        .RDATA(rdata), .SLEEP(sleep), .CAPCMP1_TRIG(trg[0]), .CAPCMP2_TRIG(trg[1]),
        .PORT_DIR(dir), .PORT_OUT(pout), .PIN_I(pin), .PIN_O(), .PIN_OE(), .PIN_RD(),
        .OSC_RUN(osc_run), .IRQ(irq), .WAKE(wake), .TIME_BASE(), .TIME_BASE_VALID(tbv));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // ========================================
    // bus and compare tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] t = 2'b00);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        trg <= t;
        @(posedge clk);
        we <= 1'b0;
        trg <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    // software stops the counter before touching the count
    task automatic setcnt(input int v);
        wr(TMO_OFS_CTRL, 8'h00);
        wr(TMO_OFS_CNT_HI, 8'(v >> 8));
        wr(TMO_OFS_CNT_LO, 8'(v));
    endtask
    // counter is stopped first or its pin held still, so no carry slips between the byte reads
    task automatic chk_cnt(input int e);
        rd(TMO_OFS_CNT_HI);
        chk8(got, 8'(e >> 8));
        rd(TMO_OFS_CNT_LO);
        chk8(got, 8'(e));
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    // ========================================
    // scenarios
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(TMO_OFS_CTRL);
        chk8(got, TMO_CTRL_RESET);
        rd(8'h55);
        chk8(got, 8'h00);
        wr(TMO_OFS_CTRL, 8'hFF);
        rd(TMO_OFS_CTRL);
        chk8(got, TMO_CTRL_MASK);
        chk1(osc_run, 1'b1);
        // timer mode: whole instruction cycles per prescale step
        for (int p = 0; p < 4; p++) begin
            seed = lfsr(seed);
            ec = seed[15:0];
            dir <= seed[17:16];
            pout <= seed[19:18];
            setcnt(ec);
            wr(TMO_OFS_CTRL, 8'(1 + p * 16));
            repeat ((3 << p) * 4 - 2) @(posedge clk);
            wr(TMO_OFS_CTRL, 8'h00);
            chk_cnt((ec + 3) & 16'hFFFF);
        end
        // counter modes, first rise after enable must not count
        for (int m = 0; m < 3; m++) begin
            for (int p = 0; p < 4; p++) begin
                seed = lfsr(seed);
                ec = seed[15:0];
                n = 6 + p + m;
                src.set(m / 2, 1'b0);
                setcnt(ec);
                wr(TMO_OFS_CTRL, md[m] | 8'(p * 16));
                src.set(m / 2, 1'b1);
                chk1(tbv, !md[m][TMO_BIT_NOSYNC]);
                sleep <= p[0];
                src.pulses(m / 2, n, 3 + m);
                sleep <= 1'b0;
                if (!(p[0] && m != 1))
                    ec = (ec + (n >> p)) & 16'hFFFF;
                wr(TMO_OFS_CTRL, 8'h00);
                chk_cnt(ec);
            end
        end
        // wrap, flag and request
        setcnt(16'hFFFF);
        src.set(0, 1'b1);
        wr(TMO_OFS_CTRL, 8'h07);
        src.pulses(0, 1, 3);
        chk1(irq, 1'b0);
        rd(TMO_OFS_FLAG);
        chk8(got, 8'h01);
        wr(TMO_OFS_ENABLE, 8'h01);
        #1 chk1(irq, 1'b1);
        @(posedge clk);
        sleep <= 1'b1;
        #1 chk1(wake, 1'b1);
        wr(TMO_OFS_FLAG, 8'h00);
        sleep <= 1'b0;
        #1 chk1(irq, 1'b0);
        chk1(wake, 1'b0);
        chk_cnt(0);
        // clear by trigger, and write beating trigger
        setcnt(16'h1234);
        wr(TMO_OFS_CTRL, 8'h02);
        wr(8'h55, 8'h00, 2'b01);
        chk_cnt(0);
        rd(TMO_OFS_FLAG);
        chk8(got, 8'h00);
        wr(TMO_OFS_CNT_LO, 8'h22, 2'b10);
        chk_cnt(16'h0022);
        // reset with the oscillator enabled keeps the count and clears control
        wr(TMO_OFS_CTRL, 8'h08);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk_cnt(16'h0022);
        rd(TMO_OFS_CTRL);
        chk8(got, TMO_CTRL_RESET);
        chk1(osc_run, 1'b0);
        end_of_test();
    end
endmodule
bind tmo_timer tmo_timer_chk u_chk (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
    .WE(WE), .RE(RE), .RDATA(RDATA), .SLEEP(SLEEP), .CAPCMP1_TRIG(CAPCMP1_TRIG),
    .CAPCMP2_TRIG(CAPCMP2_TRIG), .PORT_DIR(PORT_DIR), .PORT_OUT(PORT_OUT), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .PIN_RD(PIN_RD), .OSC_RUN(OSC_RUN), .IRQ(IRQ), .WAKE(WAKE),
    .TIME_BASE(TIME_BASE), .TIME_BASE_VALID(TIME_BASE_VALID));
